// [rtl/ifra_bridge.sv]
/*
 * indirect access port: a data and a command register that let the host
 * reach the switch fabric's internal registers.
 * assumes a synchronous host register port and a fabric that answers each
 * request with a one-cycle done pulse, both on clk.
 */
`timescale 1ns/1ps
`default_nettype none

`include "ifra_defines.svh"

// Functional notes
// - data register buffers every fabric transfer
// - command address field selects fabric register
// - read direction returns fetched fabric data
// - write direction returns last host-written value
// - writing busy one starts the access
// - busy holds during access, self-clears, resets zero
// - read busy clears once data captured
// - direction bit thirty, one means read
// - auto-increment write starts access, then increments
// - auto-increment read increments, starts next read
// - auto-decrement write starts access, then decrements
// - auto-decrement read decrements, starts next read
// - increment wins over decrement
// - bits twenty-seven to twenty read zero
// - write updates only enabled byte lanes
module ifra_bridge (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // host register port
   input wire ifra_pkg::ifra_host_req_s host_req,
   output logic [31:0] host_rdata,
   output logic host_rvalid,
   // fabric register space
   output ifra_pkg::ifra_fab_req_s fab_req,
   input wire logic fab_done,
   input wire logic [31:0] fab_rdata
);

   logic [31:0] wdata_q;
   logic [31:0] rdata_q;
   logic busy_q;
   logic dir_q;
   logic inc_q;
   logic dec_q;
   logic [3:0] lanes_q;
   logic [15:0] addr_q;
   ifra_pkg::ifra_state_e state_q;
   ifra_pkg::ifra_state_e state_d;
   logic step_pend_q;
   logic [31:0] host_rdata_q;
   logic host_rvalid_q;

   // host address decode
   wire hit_data = host_req.addr == `IFRA_OFS_DATA;
   wire hit_cmd = host_req.addr == `IFRA_OFS_CMD;
   wire wr_data = host_req.wr && hit_data;
   wire wr_cmd = host_req.wr && hit_cmd;
   wire rd_data = host_req.rd && hit_data;
   wire auto_on = inc_q || dec_q;

   // increment wins over decrement; wraps modulo 16 bits
   wire [15:0] addr_step = inc_q ? addr_q + `IFRA_ADDR_STEP
                                 : addr_q - `IFRA_ADDR_STEP;

   // accesses that start: explicit busy write or auto data access
   wire start_cmd = wr_cmd && host_req.wdata[`IFRA_BIT_BUSY];
   wire start_wr = wr_data && auto_on && !dir_q;
   wire start_rd = rd_data && auto_on && dir_q && !busy_q;
   wire start_any = (start_cmd || start_wr || start_rd) && state_q == ifra_pkg::IFRA_IDLE;
   wire access_end = state_q == ifra_pkg::IFRA_WAIT && fab_done;

   // register readback; reserved bits read zero
   wire [31:0] cmd_view = {busy_q, dir_q, inc_q, dec_q, 8'h00, lanes_q, addr_q};
   wire [31:0] data_view = dir_q ? rdata_q : wdata_q;
   wire [31:0] rd_mux = hit_data ? data_view : (hit_cmd ? cmd_view : 32'h0000_0000);

   // engine next state
   always_comb begin
      case (state_q)
         ifra_pkg::IFRA_IDLE: state_d = start_any ? ifra_pkg::IFRA_ISSUE : ifra_pkg::IFRA_IDLE;
         ifra_pkg::IFRA_ISSUE: state_d = ifra_pkg::IFRA_WAIT;
         ifra_pkg::IFRA_WAIT: state_d = fab_done ? ifra_pkg::IFRA_IDLE : ifra_pkg::IFRA_WAIT;
         default: state_d = ifra_pkg::IFRA_IDLE;
      endcase
   end

   // engine state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ifra_pkg::IFRA_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // busy flag: set on start, cleared when the fabric answers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
      end else if (start_any) begin
         busy_q <= 1'b1;
      end else if (access_end) begin
         busy_q <= 1'b0;
      end
   end

   // write buffer holds last host value
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wdata_q <= `IFRA_DATA_RST;
      end else if (wr_data) begin
         wdata_q <= host_req.wdata;
      end
   end

   // read buffer catches fabric data in the same edge busy drops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= `IFRA_DATA_RST;
      end else if (access_end && dir_q) begin
         rdata_q <= fab_rdata;
      end
   end

   // command fields; writes ignored while busy
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dir_q <= 1'b0;
         inc_q <= 1'b0;
         dec_q <= 1'b0;
         lanes_q <= `IFRA_BE_RST;
      end else if (wr_cmd && !busy_q) begin
         dir_q <= host_req.wdata[`IFRA_BIT_DIR];
         inc_q <= host_req.wdata[`IFRA_BIT_INC];
         dec_q <= host_req.wdata[`IFRA_BIT_DEC];
         lanes_q <= host_req.wdata[`IFRA_BE_HI:`IFRA_BE_LO];
      end
   end

   // write steps address after it completes; read steps before it starts
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_q <= `IFRA_ADDR_RST;
         step_pend_q <= 1'b0;
      end else if (wr_cmd && !busy_q) begin
         addr_q <= host_req.wdata[`IFRA_ADDR_HI:`IFRA_ADDR_LO];
         step_pend_q <= 1'b0;
      end else if (start_rd) begin
         addr_q <= addr_step;
      end else if (start_wr && state_q == ifra_pkg::IFRA_IDLE) begin
         step_pend_q <= 1'b1;
      end else if (access_end && step_pend_q) begin
         addr_q <= addr_step;
         step_pend_q <= 1'b0;
      end
   end

   // fabric request, launched out of the issue state so that a command
   // written on the start edge has already landed in the field registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fab_req <= '0;
      end else begin
         fab_req.req <= state_q == ifra_pkg::IFRA_ISSUE;
         fab_req.write <= !dir_q;
         fab_req.addr <= addr_q;
         fab_req.lanes <= lanes_q;
         fab_req.wdata <= wdata_q;
      end
   end

   // host read answer, one cycle after the request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         host_rdata_q <= 32'h0000_0000;
         host_rvalid_q <= 1'b0;
      end else begin
         host_rdata_q <= rd_mux;
         host_rvalid_q <= host_req.rd;
      end
   end

   assign host_rdata = host_rdata_q;
   assign host_rvalid = host_rvalid_q;

endmodule : ifra_bridge

`default_nettype wire

// [rtl/ifra_defines.svh]
/*
 * register offsets, field positions and reset values of the indirect
 * fabric register access port.
 * assumes inclusion by bare name from files compiled after it.
 */
`ifndef IFRA_DEFINES_SVH
`define IFRA_DEFINES_SVH

`define IFRA_OFS_DATA 12'h1ac
`define IFRA_OFS_CMD 12'h1b0
`define IFRA_BIT_BUSY 31
`define IFRA_BIT_DIR 30
`define IFRA_BIT_INC 29
`define IFRA_BIT_DEC 28
`define IFRA_BE_HI 19
`define IFRA_BE_LO 16
`define IFRA_ADDR_HI 15
`define IFRA_ADDR_LO 0
`define IFRA_DATA_RST 32'h0000_0000
`define IFRA_ADDR_RST 16'h0000
`define IFRA_BE_RST 4'h0
`define IFRA_ADDR_STEP 16'h0001

`endif

// [rtl/ifra_pkg.sv]
/*
 * types shared by the indirect fabric register access port.
 * assumes ifra_defines.svh supplies the numeric constants.
 */
package ifra_pkg;

   // host register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [31:0] wdata;
   } ifra_host_req_s;

   // request towards the fabric register space
   typedef struct packed {
      logic req;
      logic write;
      logic [15:0] addr;
      logic [3:0] lanes;
      logic [31:0] wdata;
   } ifra_fab_req_s;

   // engine states, gray along idle -> issue -> wait
   typedef enum logic [1:0] {
      IFRA_IDLE = 2'b00,
      IFRA_ISSUE = 2'b01,
      IFRA_WAIT = 2'b11
   } ifra_state_e;

endpackage : ifra_pkg

// [verification/ifra_bridge_props.sv]
/* checker bound to the fabric access bridge.
   assumes the host writes the command register only while idle. */
`timescale 1ns/1ps
`default_nettype none
`include "ifra_defines.svh"
module ifra_bridge_props (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // host side
   input wire ifra_pkg::ifra_host_req_s host_req,
   input wire logic [31:0] host_rdata,
   input wire logic host_rvalid,
   // fabric side
   input wire ifra_pkg::ifra_fab_req_s fab_req,
   input wire logic fab_done,
   input wire logic [31:0] fab_rdata
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // decoded host strobes
   wire go = host_req.wr && host_req.addr == `IFRA_OFS_CMD && host_req.wdata[31];
   wire rc = host_req.rd && host_req.addr == `IFRA_OFS_CMD;
   sequence s_req;
      ##2 fab_req.req;
   endsequence
   // host answers and the launch of each access started by a busy-bit command write
   AST_RV: assert property (host_req.rd |=> host_rvalid) else $error("rv");
   AST_NRV: assert property (!host_req.rd |=> !host_rvalid) else $error("rv");
   AST_GO: assert property (go |-> s_req) else $error("start");
   AST_DIR: assert property (go |-> ##2 fab_req.write != $past(host_req.wdata[30], 2))
      else $error("dir");
   AST_ADR: assert property (go |-> ##2 fab_req.addr == $past(host_req.wdata[15:0], 2))
      else $error("addr");
   AST_BE: assert property (go |-> ##2 fab_req.lanes == $past(host_req.wdata[19:16], 2))
      else $error("lanes");
   AST_RSV: assert property (rc |=> host_rdata[27:20] == 8'h00) else $error("rsv");
   AST_ONE: assert property (fab_req.req |=> !fab_req.req) else $error("pulse");
endmodule : ifra_bridge_props
bind ifra_bridge ifra_bridge_props chk_u (.clk(clk), .rst_n(rst_n), .host_req(host_req),
   .host_rdata(host_rdata), .host_rvalid(host_rvalid), .fab_req(fab_req),
   .fab_done(fab_done), .fab_rdata(fab_rdata));
`default_nettype wire

// [verification/ifra_fabric_model.sv]
/* fabric register space model. assumes one request at a time. */
`timescale 1ns/1ps
`default_nettype none
module ifra_fabric_model (
   // clock, reset, answer delay
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] dly,
   // bridge side
   input wire ifra_pkg::ifra_fab_req_s fab_req,
   output logic fab_done,
   output logic [31:0] fab_rdata
);
   logic [31:0] mem [0:65535];
   logic [3:0] n_q;
   ifra_pkg::ifra_fab_req_s h_q;
   // count down, answer, scramble the idle data bus
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         n_q <= 4'h0;
         fab_done <= 1'b0;
         fab_rdata <= 32'h0000_0000;
      end else begin
         fab_done <= n_q == 4'h1;
         fab_rdata <= (n_q == 4'h1) ? mem[h_q.addr] : ~fab_rdata;
         n_q <= fab_req.req ? dly + 4'h1 : n_q - {3'h0, n_q != 4'h0};
         if (fab_req.req) h_q <= fab_req;
         for (int i = 0; i < 4; i++)
            if (n_q == 4'h1 && h_q.write && h_q.lanes[i]) mem[h_q.addr][i*8+:8] <= h_q.wdata[i*8+:8];
      end
   end
endmodule : ifra_fabric_model
`default_nettype wire

// [verification/tb_indirect_fabric_reg_access.sv]
/* bench for the fabric access bridge. assumes the fabric model and checker. */
`timescale 1ns/1ps
`default_nettype none
`include "ifra_defines.svh"
module tb_indirect_fabric_reg_access;
   localparam logic [11:0] od = `IFRA_OFS_DATA;
   localparam logic [11:0] oc = `IFRA_OFS_CMD;
   logic clk, rst_n, rv, dn;
   logic [3:0] dly;
   logic [31:0] rd, frd, q;
   ifra_pkg::ifra_host_req_s hq;
   ifra_pkg::ifra_fab_req_s fq;
   int fails, checks_done, cyc;
   ifra_bridge dut_u (.clk(clk), .rst_n(rst_n), .host_req(hq), .host_rdata(rd),
      .host_rvalid(rv), .fab_req(fq), .fab_done(dn), .fab_rdata(frd));
   ifra_fabric_model fab_u (.clk(clk), .rst_n(rst_n), .dly(dly), .fab_req(fq),
      .fab_done(dn), .fab_rdata(frd));
   // clock and cycle ceiling
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fails++;
         tally_and_finish();
      end
   end
   task automatic ck(input string n, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH %s exp %h seen %h", n, e, s);
      end
   endtask : ck
   // one host access, read data sampled with rvalid
   task automatic ax(input logic w, input logic [11:0] a, input logic [31:0] d);
      hq = '{w, !w, a, d};
      @(posedge clk) #1;
      q = rd;
      hq = '0;
      if (!w) ck("rvalid", rv, 32'h0000_0001);
      @(posedge clk) #1;
   endtask : ax
   task automatic idle();
      ax(1'b0, oc, 32'h0000_0000);
      for (int i = 0; i < 40 && q[31]; i++)
         ax(1'b0, oc, 32'h0000_0000);
   endtask : idle
   // slow partial write, then read back both ways
   task automatic t_rw();
      fab_u.mem[16] = 32'hffff_ffff;
      ax(1'b1, od, 32'ha5a5_1234);
      idle();
      ck("store", q, 32'h0000_0000);
      ax(1'b1, oc, 32'h80f3_0010);
      idle();
      ck("cmd", q, 32'h0003_0010);
      ck("lanes", fab_u.mem[16], 32'hffff_1234);
      ax(1'b1, oc, 32'hc00f_0010);
      idle();
      ax(1'b0, od, 32'h0000_0000);
      ck("fetch", q, 32'hffff_1234);
      ax(1'b1, oc, 32'h000f_0010);
      ax(1'b0, od, 32'h0000_0000);
      ck("held", q, 32'ha5a5_1234);
   endtask : t_rw
   // auto steps: wrap up, both bits set, step down
   task automatic t_auto();
      fab_u.mem[0] = 32'h0000_00aa;
      fab_u.mem[1] = 32'h0000_00bb;
      ax(1'b1, oc, 32'h200f_ffff);
      ax(1'b1, od, 32'h1111_0000);
      idle();
      ck("wrap", q, 32'h200f_0000);
      ck("wmem", fab_u.mem[65535], 32'h1111_0000);
      ax(1'b1, oc, 32'hf00f_0000);
      idle();
      ax(1'b0, od, 32'h0000_0000);
      ck("rd0", q, 32'h0000_00aa);
      idle();
      ck("both", q, 32'h700f_0001);
      ax(1'b1, oc, 32'h400f_0001);
      ax(1'b0, od, 32'h0000_0000);
      ck("last", q, 32'h0000_00bb);
      idle();
      ck("nostep", q, 32'h400f_0001);
      ax(1'b1, oc, 32'h100f_0005);
      ax(1'b1, od, 32'h0000_0055);
      idle();
      ck("dec", q, 32'h100f_0004);
      ck("dmem", fab_u.mem[5], 32'h0000_0055);
   endtask : t_auto
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   // reset, then the scenarios
   initial begin
      rst_n = 1'b0;
      dly = 4'h9;
      hq = '0;
      repeat (10) @(posedge clk);
      #1 rst_n = 1'b1;
      t_rw();
      dly = 4'h0;
      t_auto();
      tally_and_finish();
   end
endmodule : tb_indirect_fabric_reg_access
`default_nettype wire
